// [acs_pkg.sv]
// Shared constants and types of the converter sequencer.
package acs_pkg;

  // ----------------------------------------------------------------------
  // Clock rates and conversion timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_HZ = 100_000_000;
  localparam int unsigned CONV_HZ = 8_000_000;
  localparam logic [6:0] TICK_STEP = 7'(CONV_HZ / 1_000_000);
  localparam logic [6:0] TICK_WRAP = 7'(SYS_HZ / 1_000_000);
  localparam logic [5:0] PREP_TICKS = 6'h03;
  localparam logic [5:0] MUX_TICKS = 6'h02;
  localparam logic [5:0] QUARTER_TICKS = 6'h20;
  localparam logic [5:0] FINE_TICKS = 6'h21;
  localparam logic [7:0] TOTAL_TICKS = 8'ha6;

  // ----------------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned DATA_BITS = 10;
  localparam int unsigned ADDR_BITS = 5;
  localparam int unsigned WR_BIT = 15;
  localparam int unsigned ADDR_LSB = 10;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] ADDR_DONE_BIT = 4'h6;
  localparam logic [4:0] RESULT_ADDR_FIRST = 5'h01;
  localparam logic [4:0] RESULT_ADDR_LAST = 5'h03;
  localparam int unsigned RESULT_REGS = 3;

  typedef enum logic [3:0]
  {
    ACS_IDLE = 4'h0,
    ACS_PREP = 4'h1,
    ACS_MUX = 4'h2,
    ACS_SETTLE1 = 4'h3,
    ACS_INTEG1 = 4'h4,
    ACS_SETTLE2 = 4'h5,
    ACS_INTEG2 = 4'h6,
    ACS_FINE = 4'h7,
    ACS_STORE = 4'h8
  } acs_phase_t;

  typedef struct packed {
    logic cs_n;
    logic sclk_rise;
    logic sclk_fall;
    logic mosi;
  } acs_link_t;

  typedef struct packed {
    logic integrate;
    logic fine;
    logic input_polarity_switch;
    logic amplifier_polarity_switch;
  } acs_front_t;

endpackage : acs_pkg

// [acs_pin_sync.sv]
// Two-stage synchroniser with edge detection for link pins.
`timescale 1ns/100ps
module acs_pin_sync #(
  parameter int W = 3
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] pin_in, // Raw pins from outside.
  output logic [W-1:0] level, // Synchronised level.
  output logic [W-1:0] rise, // One-cycle pulse on a rising edge.
  output logic [W-1:0] fall // One-cycle pulse on a falling edge.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } acs_sync_t;

  acs_sync_t st_reg;
  acs_sync_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Edges compare stages two and three; the first stage feeds stage two only.
  assign level = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
  assign fall = ~st_reg.s2 & st_reg.s3;

endmodule : acs_pin_sync

// [acs_sequencer.sv]
// Conversion sequencer with its serial front end and result registers.
// Operation
// [R1] The converter delivers a ten-bit differential result.
// [R2] Only a host write to a result register starts a conversion.
// [R3] Conversion runs 128 integration then 33 fine cycles at 8 MHz.
// [R4] Integration opens with 32 settling cycles, then 32 integrating cycles.
// [R5] Polarity reverses, then 32 settling and 32 integrating cycles follow.
// [R6] In the 33 fine cycles input changes no longer affect the result.
// [R7] After all 166 cycles the result is latched for the host.
// [R8] The multiplexer routes the requested channel to the converter.
// [R9] The stored result is unsigned, 0 to 1023, linear over full scale.
// [R10] Any conversion delays short detection since switches are shared.
// [R11] An offset reading of a load channel delays its detection further.
// [R12] Amplifier and input polarity swap halfway through integration.
// [R13] Each load channel has a chopped comparator with its own threshold.
// [R14] The host alone decides when conversions take place.
// [R15] The host subtracts offsets using 16-bit signed arithmetic.
// [R16] Link idles clock high, samples rising edges, MSB first, 16-bit words.
// [R17] A write takes effect on each 16th rising edge; surplus is ignored.
// [R18] Register space is 32 words of ten data bits.
// [R19] A result register holds its value until a new conversion completes.
`timescale 1ns/100ps
module acs_sequencer #(
  parameter int CHANNELS = 5,
  parameter int THR_BITS = 4,
  parameter logic [9:0] OFS_CHAN_BASE = 10'h010,
  parameter logic [7:0] SC_EXTRA_TICKS = 8'h40
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic link_sclk, // Serial clock pin, idles high.
  input wire logic link_cs_n, // Serial select pin, active low.
  input wire logic link_mosi, // Serial data from the host.
  output logic link_miso, // Serial data to the host.
  output logic link_miso_oe, // High while the block drives the data pin.
  input wire logic [9:0] conv_code, // Code from the analog converter.
  input wire logic [CHANNELS*THR_BITS-1:0] thr_cfg, // Threshold settings.
  output logic [9:0] mux_sel, // Channel routed to the converter.
  output acs_pkg::acs_front_t front, // Analog phase and switch controls.
  output logic conv_busy, // Conversion in progress.
  output logic sc_blank, // Short detection held off, all channels.
  output logic [CHANNELS-1:0] sc_extra_blank, // Extra hold-off per channel.
  output logic sc_chop, // Comparator chopper phase.
  output logic [CHANNELS*THR_BITS-1:0] short_threshold_reference // Refs.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int RESULT_REGS_W = acs_pkg::RESULT_REGS;
  typedef struct packed {
    logic [15:0] rx;
    logic [15:0] tx;
    logic [3:0] bit_cnt;
    logic miso;
    logic [6:0] acc;
    acs_pkg::acs_phase_t phase;
    logic [5:0] cnt;
    logic [1:0] slot;
    logic [9:0] chan;
    logic pol;
    logic [RESULT_REGS_W-1:0][9:0] conversion_result_register;
    logic [CHANNELS-1:0] extra_mask;
    logic [7:0] extra_cnt;
    logic [4:0] chop_cnt;
    logic [CHANNELS*THR_BITS-1:0] thr;
  } acs_state_t;

  acs_state_t st_reg;
  acs_state_t st_next;
  acs_pkg::acs_link_t lk;
  logic [2:0] sync_level;
  logic [2:0] sync_rise;
  logic [2:0] sync_fall;
  logic tick;
  logic [15:0] word;
  logic [4:0] word_addr;
  logic wr_apply;
  logic start_req;
  logic [1:0] rd_slot;

  acs_pin_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({~link_sclk, ~link_cs_n, link_mosi}),
    .level(sync_level),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  // Clock and select idle high, so they pass the synchroniser inverted.
  // Its zero reset then equals their idle level and no false edge follows.
  assign lk.cs_n = ~sync_level[1]; // [R16]
  assign lk.sclk_rise = sync_fall[2] & sync_level[1];
  assign lk.sclk_fall = sync_rise[2] & sync_level[1];
  assign lk.mosi = sync_level[0];

  function automatic logic [5:0] phase_len(acs_pkg::acs_phase_t p);
    unique case (p)
      acs_pkg::ACS_PREP: phase_len = acs_pkg::PREP_TICKS;
      acs_pkg::ACS_MUX: phase_len = acs_pkg::MUX_TICKS;
      acs_pkg::ACS_FINE: phase_len = acs_pkg::FINE_TICKS;
      default: phase_len = acs_pkg::QUARTER_TICKS;
    endcase
  endfunction : phase_len

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  assign tick = (st_reg.acc + acs_pkg::TICK_STEP) >= acs_pkg::TICK_WRAP;
  assign word = {st_reg.rx[14:0], lk.mosi};
  assign word_addr = word[acs_pkg::ADDR_LSB +: acs_pkg::ADDR_BITS];
  // Each sixteenth rising edge completes a word; a partial tail never does.
  assign wr_apply = lk.sclk_rise && st_reg.bit_cnt == acs_pkg::LAST_BIT
    && word[acs_pkg::WR_BIT]; // [R17]
  // Writes during a conversion are dropped so a running reading completes.
  assign start_req = wr_apply && st_reg.phase == acs_pkg::ACS_IDLE
    && word_addr >= acs_pkg::RESULT_ADDR_FIRST
    && word_addr <= acs_pkg::RESULT_ADDR_LAST; // [R2] [R14]
  assign rd_slot = 2'(st_reg.rx[4:0] - acs_pkg::RESULT_ADDR_FIRST);

  always_comb
  begin
    st_next = st_reg;
    st_next.thr = thr_cfg; // [R13]
    st_next.chop_cnt = st_reg.chop_cnt + (tick ? 5'h01 : 5'h00); // [R13]
    st_next.acc = tick ? 7'(st_reg.acc + acs_pkg::TICK_STEP
      - acs_pkg::TICK_WRAP) : 7'(st_reg.acc + acs_pkg::TICK_STEP);
    // Serial receive and transmit.
    if (lk.cs_n)
    begin
      st_next.bit_cnt = '0;
      st_next.tx = '0;
      st_next.miso = 1'b0;
    end
    else
    begin
      if (lk.sclk_rise)
      begin
        st_next.rx = word; // [R16]
        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
      end
      if (lk.sclk_fall)
      begin
        if (st_reg.bit_cnt == acs_pkg::ADDR_DONE_BIT)
        begin
          if (st_reg.rx[4:0] >= acs_pkg::RESULT_ADDR_FIRST
              && st_reg.rx[4:0] <= acs_pkg::RESULT_ADDR_LAST)
          begin
            st_next.miso = st_reg.conversion_result_register[rd_slot][9]; // [R18]
            st_next.tx = {st_reg.conversion_result_register[rd_slot][8:0], 7'h00};
          end
          else
          begin
            st_next.miso = 1'b0;
            st_next.tx = '0;
          end
        end
        else
        begin
          st_next.miso = st_reg.tx[15];
          st_next.tx = {st_reg.tx[14:0], 1'b0};
        end
      end
    end
    // Conversion phases.
    if (start_req)
    begin
      st_next.phase = acs_pkg::ACS_PREP;
      st_next.cnt = '0;
      st_next.pol = 1'b0;
      st_next.slot = 2'(word_addr - acs_pkg::RESULT_ADDR_FIRST);
      st_next.chan = word[9:0]; // [R8]
    end
    else if (st_reg.phase == acs_pkg::ACS_STORE)
    begin
      st_next.conversion_result_register[st_reg.slot] = conv_code; // [R7] [R9] [R19] [R1]
      st_next.phase = acs_pkg::ACS_IDLE;
      for (int k = 0; k < CHANNELS; k++)
      begin
        if (st_reg.chan == 10'(OFS_CHAN_BASE + k))
        begin
          st_next.extra_mask = CHANNELS'(1) << k; // [R11]
          st_next.extra_cnt = SC_EXTRA_TICKS;
        end
      end
    end
    else if (tick && st_reg.phase != acs_pkg::ACS_IDLE)
    begin
      if (st_reg.cnt == 6'(phase_len(st_reg.phase) - 6'h01))
      begin
        st_next.cnt = '0; // [R3] [R4] [R5]
        st_next.phase = acs_pkg::acs_phase_t'(st_reg.phase + 4'h1);
        if (st_reg.phase == acs_pkg::ACS_INTEG1)
          st_next.pol = 1'b1; // [R5] [R12]
      end
      else
        st_next.cnt = st_reg.cnt + 6'h01;
    end
    if (st_reg.phase != acs_pkg::ACS_STORE && tick
        && st_reg.extra_mask != '0)
    begin
      if (st_reg.extra_cnt == 8'h00)
        st_next.extra_mask = '0;
      else
        st_next.extra_cnt = st_reg.extra_cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign link_miso = st_reg.miso;
  assign link_miso_oe = ~lk.cs_n;
  assign mux_sel = st_reg.chan;
  assign conv_busy = st_reg.phase != acs_pkg::ACS_IDLE;
  assign sc_blank = conv_busy; // [R10]
  assign sc_extra_blank = st_reg.extra_mask;
  // The chopper follows the shared switch while converting.
  assign sc_chop = conv_busy ? st_reg.pol : st_reg.chop_cnt[4]; // [R13]
  assign short_threshold_reference = st_reg.thr;
  assign front.integrate = st_reg.phase == acs_pkg::ACS_INTEG1
    || st_reg.phase == acs_pkg::ACS_INTEG2; // [R4]
  assign front.fine = st_reg.phase == acs_pkg::ACS_FINE; // [R6]
  assign front.input_polarity_switch = st_reg.pol; // [R12]
  assign front.amplifier_polarity_switch = st_reg.pol;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [7:0] tick_total;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_total <= '0;
    else if (start_req)
      tick_total <= '0;
    else if (tick && conv_busy && st_reg.phase != acs_pkg::ACS_STORE)
      tick_total <= tick_total + 8'h01;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  start_by_write_a: assert property ( // [R2]
    $rose(conv_busy) |-> $past(start_req))
    else $error("conversion began without a host write");
  total_ticks_a: assert property ( // [R3]
    $rose(st_reg.phase == acs_pkg::ACS_STORE)
    |-> tick_total == acs_pkg::TOTAL_TICKS)
    else $error("conversion length is not 166 ticks");
  integ_window_a: assert property ( // [R4]
    front.integrate |-> st_reg.phase inside
    {acs_pkg::ACS_INTEG1, acs_pkg::ACS_INTEG2})
    else $error("integration outside an integration phase");
  pol_swap_a: assert property ( // [R5]
    $rose(st_reg.phase == acs_pkg::ACS_SETTLE2)
    |-> $rose(front.input_polarity_switch)
    && front.amplifier_polarity_switch)
    else $error("polarity not swapped before second settling");
  fine_frozen_a: assert property (front.fine |=> $stable(mux_sel)) // [R6]
    else $error("channel changed during fine phase");
  result_store_a: assert property ( // [R7]
    st_reg.phase == acs_pkg::ACS_STORE
    |=> st_reg.conversion_result_register[$past(st_reg.slot)] == $past(conv_code))
    else $error("result not latched at completion");
  result_hold_a: assert property ( // [R19]
    st_reg.phase != acs_pkg::ACS_STORE |=> $stable(st_reg.conversion_result_register))
    else $error("result changed without a completed conversion");
  sc_blank_a: assert property (conv_busy |-> sc_blank) // [R10]
    else $error("short detection not held off while converting");
  write_edge_a: assert property ( // [R17]
    start_req |-> lk.sclk_rise && st_reg.bit_cnt == acs_pkg::LAST_BIT)
    else $error("write applied away from the sixteenth edge");

  conv_done_c: cover property (st_reg.phase == acs_pkg::ACS_STORE);
  offset_extra_c: cover property ($rose(sc_extra_blank != '0));
  busy_write_c: cover property (wr_apply && conv_busy);
  read_out_c: cover property (lk.sclk_fall && link_miso);

endmodule : acs_sequencer

// [acs_host_model.sv]
// Host model that masters the serial link of the converter sequencer.
`timescale 1ns/100ps
module acs_host_model (
  output logic link_sclk, // Serial clock, idles high.
  output logic link_cs_n, // Select, active low.
  output logic link_mosi, // Data to the block.
  input wire logic link_miso, // Data from the block.
  input wire logic link_miso_oe // High while the block drives data.
);
  initial
  begin
    link_sclk = 1'b1;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end

  // One frame of nbits clocks; clocks past the sixteenth carry zeros.
  task automatic send(input logic [15:0] w, input int nbits,
    output logic [15:0] r);
    r = 16'h0000;
    link_cs_n = 1'b0;
    #125;
    for (int i = 0; i < nbits; i++)
    begin
      link_sclk = 1'b0;
      link_mosi = (i < 16) ? w[15-i] : 1'b0;
      #62.5;
      link_sclk = 1'b1;
      if (i < 16 && link_miso_oe === 1'b1)
        r[15-i] = link_miso;
      #62.5;
    end
    link_cs_n = 1'b1;
    // A released line must not keep showing the last bit.
    link_mosi = ~link_mosi;
    #250;
  endtask : send
endmodule : acs_host_model

// [tb_top.sv]
// Self-checking testbench of the converter sequencer.
`timescale 1ns/100ps
module tb_top;
  logic sys_clk;
  logic rst_n;
  logic link_sclk;
  logic link_cs_n;
  logic link_mosi;
  logic link_miso;
  logic link_miso_oe;
  logic [9:0] conv_code;
  logic [19:0] thr_cfg;
  logic [9:0] mux_sel;
  acs_pkg::acs_front_t front;
  logic conv_busy;
  logic sc_blank;
  logic [4:0] sc_extra_blank;
  logic sc_chop;
  logic [19:0] short_threshold_reference;
  int n_mismatch;
  int checked;

  acs_sequencer #(.SC_EXTRA_TICKS(8'h04)) acs_sequencer_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso),
    .link_miso_oe(link_miso_oe), .conv_code(conv_code), .thr_cfg(thr_cfg),
    .mux_sel(mux_sel), .front(front), .conv_busy(conv_busy),
    .sc_blank(sc_blank), .sc_extra_blank(sc_extra_blank),
    .sc_chop(sc_chop),
    .short_threshold_reference(short_threshold_reference));

  acs_host_model acs_host_model_i (
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .link_miso(link_miso), .link_miso_oe(link_miso_oe));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_range(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got,
        lo, hi);
    end
  endtask : check_range

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wait_busy(input logic lvl, input int bound);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < bound)
    begin
      tick(1);
      n++;
    end
    if (conv_busy !== lvl)
    begin
      n_mismatch++;
      $display("wrong value at %0t: busy wait ran out %h", $time, lvl);
      complete_run();
    end
  endtask : wait_busy

  task automatic read_reg(input logic [4:0] addr, input logic [9:0] exp);
    logic [15:0] r;
    acs_host_model_i.send({1'b0, addr, 10'h000}, 16, r);
    check_val({6'h00, r[9:0]}, {6'h00, exp});
  endtask : read_reg

  // One conversion with per-cycle phase bookkeeping; ticks are 12.5 cycles.
  task automatic convert(input logic [4:0] addr, input logic [9:0] chan,
    input logic [9:0] code, input int nbits, input logic [4:0] xb);
    logic [15:0] r;
    int busy_n;
    int integ_n;
    int fine_n;
    int pol_n;
    int bad_n;
    int lead_n;
    busy_n = 0;
    integ_n = 0;
    fine_n = 0;
    pol_n = 0;
    bad_n = 0;
    lead_n = -1;
    conv_code = code;
    // Counting runs beside the frame so it begins on the cycle busy rises.
    fork
      acs_host_model_i.send({1'b1, addr, chan}, nbits, r);
      begin
        wait_busy(1'b1, 400);
        check_val(16'(mux_sel), 16'(chan));
        while (conv_busy === 1'b1 && busy_n < 2300)
        begin
          busy_n++;
          if (front.integrate === 1'b1 && lead_n < 0)
            lead_n = busy_n;
          if (front.integrate === 1'b1)
            integ_n++;
          if (front.fine === 1'b1)
            fine_n++;
          if (front.integrate === 1'b1 && front.input_polarity_switch === 1'b1
            && front.amplifier_polarity_switch === 1'b1)
            pol_n++;
          if (sc_blank !== conv_busy
            || (front.integrate & front.fine) !== 1'b0
            || front.input_polarity_switch !== front.amplifier_polarity_switch)
            bad_n++;
          tick(1);
        end
      end
    join
    wait_busy(1'b0, 0);
    check_range(busy_n, 2055, 2080);
    check_range(lead_n, 452, 466);
    check_range(integ_n, 798, 802);
    check_range(pol_n, 398, 402);
    check_range(fine_n, 410, 415);
    check_val(16'(bad_n), 16'h0000);
    check_val(16'(bad_n), 16'h0000);
    tick(3);
    check_val(16'(sc_extra_blank), 16'(xb));
    check_val(16'(mux_sel), 16'(chan));
    read_reg(addr, code);
  endtask : convert

  task automatic idle_and_refusals();
    logic [15:0] r;
    int toggles;
    toggles = 0;
    check_val({6'h00, mux_sel}, 16'h0000);
    check_val(16'(front), 16'h0000);
    // Idle chopping must be seen to rise and then fall again.
    for (int i = 0; i < 500; i++)
    begin
      if (conv_busy !== 1'b0)
        toggles = toggles + 100;
      tick(1);
      if (sc_chop === 1'b1)
        toggles = toggles | 1;
      else if (toggles[0] === 1'b1)
        toggles = toggles | 2;
    end
    check_val(16'(toggles), 16'h0003);
    check_val(16'(short_threshold_reference), 16'(thr_cfg));
    thr_cfg = 20'h5a3c1;
    tick(3);
    check_val(short_threshold_reference[15:0], 16'ha3c1);
    for (int a = 1; a <= 3; a++)
      read_reg(5'(a), 10'h000);
    read_reg(5'h07, 10'h000);
    acs_host_model_i.send(16'h9405, 16, r);
    acs_host_model_i.send(16'h8405, 10, r);
    tick(30);
    check_val({15'h0000, conv_busy}, 16'h0000);
  endtask : idle_and_refusals

  task automatic busy_write_refused();
    logic [15:0] r;
    fork
      convert(5'h01, 10'h005, 10'h3ff, 16, 5'h00);
      begin
        #6000;
        acs_host_model_i.send(16'h8807, 16, r);
      end
    join
    read_reg(5'h02, 10'h000);
  endtask : busy_write_refused

  // The host subtracts an offset reading; the result may go below zero.
  task automatic offset_compensate();
    logic [15:0] raw;
    logic [15:0] ofs;
    acs_host_model_i.send(16'h0800, 16, raw);
    acs_host_model_i.send(16'h0c00, 16, ofs);
    check_val({6'h00, raw[9:0]} - {6'h00, ofs[9:0]}, 16'hfd5b);
  endtask : offset_compensate

  initial
  begin
    rst_n = 1'b0;
    conv_code = 10'h000;
    thr_cfg = 20'h12345;
    n_mismatch = 0;
    checked = 0;
    tick(10);
    rst_n = 1'b1;
    tick(10);
    idle_and_refusals();
    busy_write_refused();
    convert(5'h02, 10'h00a, 10'h000, 20, 5'h00);
    read_reg(5'h01, 10'h3ff);
    convert(5'h03, 10'h012, 10'h2a5, 16, 5'h04);
    read_reg(5'h02, 10'h000);
    offset_compensate();
    complete_run();
  end
endmodule : tb_top
